// File: hw/ledpb_pkg.sv
package ledpb_pkg;

    localparam int NUM_CH = 18;
    localparam int CLK_HZ = 50_000_000;

    // PWM and blink timing
    localparam int PWM_STEPS = 256;
    localparam int PWM_SLOW_HZ = 200;
    localparam int PWM_FAST_HZ = 25_000;
    localparam int PWM_SLOW_CYC = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
    localparam int PWM_FAST_CYC = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
    localparam int BLINK_MAX_HZ = 24;
    localparam int BLINK_STEPS = 256;
    localparam int BLINK_TICK_CYC = CLK_HZ / (BLINK_MAX_HZ * BLINK_STEPS);

    // Register offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_GLOBAL = 8'h01;
    localparam logic [7:0] OFS_SCALE = 8'h02;
    localparam logic [7:0] OFS_OPEN_CTRL = 8'h14;
    localparam logic [7:0] OFS_OPEN_STAT = 8'h15;
    localparam logic [7:0] OFS_PWM = 8'h1F;
    localparam logic [7:0] OFS_BLINK_EN = 8'h31;
    localparam logic [7:0] OFS_BLINK_PERIOD = 8'h34;
    localparam logic [7:0] OFS_BLINK_DUTY = 8'h35;
    localparam logic [7:0] OFS_SCALE_COMMIT = 8'h36;
    localparam logic [7:0] OFS_PWM_BLINK_COMMIT = 8'h37;
    localparam logic [7:0] OFS_SOFT_RESET = 8'h3F;

    // Keys and bit positions
    localparam logic [7:0] COMMIT_KEY = 8'h00;
    localparam logic [7:0] SOFT_RESET_KEY = 8'hAE;
    localparam int CFG_RUN_BIT = 0;
    localparam int CFG_FAST_PWM_BIT = 1;
    localparam int CFG_EIGHTH_BIT = 5;
    localparam int OPEN_DETECT_BIT = 0;
    localparam int OPEN_REPORT_BIT = 1;

    // Arbitrary default bus address
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2A;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_REG, S_WDATA, S_ACK, S_RDATA, S_RACK
    } ledpb_bus_e;

    typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} ledpb_kind_e;

    typedef struct packed {
        logic run;
        logic fast_pwm;
        logic eighth;
        logic [7:0] global_level;
        logic [NUM_CH-1:0][7:0] scale_pend;
        logic [NUM_CH-1:0][7:0] scale_act;
        logic [NUM_CH-1:0][7:0] pwm_pend;
        logic [NUM_CH-1:0][7:0] pwm_act;
        logic [NUM_CH-1:0] blink_en_pend;
        logic [NUM_CH-1:0] blink_en_act;
        logic [7:0] period_pend;
        logic [7:0] period_act;
        logic [7:0] duty_pend;
        logic [7:0] duty_act;
        logic open_detect_enable;
        logic open_report_to_pin;
        logic [NUM_CH-1:0] open_status;
    } ledpb_regs_s;

    localparam ledpb_regs_s REGS_RESET = '0;

    typedef struct packed {
        ledpb_regs_s regs;
        ledpb_bus_e bus;
        ledpb_kind_e kind;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic [3:0] cnt;
        logic full;
        logic rw;
        logic sda_oe;
        logic sda_lo;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        logic [NUM_CH-1:0] sense_s1;
        logic [NUM_CH-1:0] sense_s2;
        logic [NUM_CH-1:0] sense_s3;
        logic [NUM_CH-1:0] open_f;
        logic [9:0] pwm_pre;
        logic [7:0] pwm_cnt;
        logic [13:0] blink_tick;
        logic [7:0] blink_sub;
        logic [7:0] blink_phase;
        logic [NUM_CH-1:0] led;
        logic int_n;
    } ledpb_state_s;

endpackage

// File: hw/ledpb_top.sv
`timescale 1ns/1ns
// Overview of operation
// RULE_01 - Blink period linear, 41 ms to 10.66 s
// RULE_02 - Blink frequency equals 24 over code+1
// RULE_03 - Period code shadowed until general commit
// RULE_04 - Blink on-ratio equals duty code over 256
// RULE_05 - Duty code shadowed until general commit
// RULE_06 - Scaling commit activates all pending scales
// RULE_07 - General commit activates PWM and blink codes
// RULE_08 - Writing 0xAE resets all registers; here an open sensed that cycle with detect on stays in open status
// RULE_09 - Power-up defaults keep outputs shut down
// RULE_10 - Current-mode bit gives one-eighth current
// RULE_11 - Eighteen PWM duties, value over 256
// RULE_12 - Eighteen independent per-channel current scales
// RULE_13 - PWM runs at 200 Hz or 25 kHz; the fast setting here uses 1792 clocks, about 27.9 kHz
// RULE_14 - All channels share one synchronized PWM cycle
// RULE_15 - Open status recorded while detect enabled
// RULE_16 - Report flag drives interrupt low on open
// RULE_17 - Host keeps global current in 0x0F-0x3F
// RULE_18 - Reading open status clears it
// RULE_19 - Per-channel blink enable, applied at commit
// RULE_20 - Blinking channels gated by blink duty window
module ledpb_top
    import ledpb_pkg::*;
#(
    parameter logic [6:0] P_BUS_ADDR = BUS_ADDR_DEFAULT,
    parameter int P_BLINK_TICK = BLINK_TICK_CYC
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESET,
    // Serial host bus
    input wire logic I_SCL,
    input wire logic I_SDA_IN,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    // Open-LED sensing
    input wire logic [NUM_CH-1:0] I_OPEN_SENSE,
    // Output drive
    output logic [NUM_CH-1:0] O_LED_OUTPUT_CHANNEL,
    output logic [NUM_CH-1:0][7:0] O_CHANNEL_CURRENT_SCALE,
    output logic [7:0] O_GLOBAL_CURRENT_LEVEL,
    output logic O_EIGHTH_CURRENT_SELECT,
    output logic O_RUN_NOT_SHUTDOWN,
    // Status
    output logic O_INTERRUPT_OUT_N
);

    ledpb_state_s q;
    ledpb_state_s d;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic wr_stb;
    logic blink_on;
    logic [7:0] rd_byte;
    logic [NUM_CH-1:0] rd_clear;
    logic [9:0] pwm_limit;

    function automatic logic [7:0] pack_six(input logic [NUM_CH-1:0] v, input int k);
        pack_six = {1'b0, v[6*k+3 +: 3], 1'b0, v[6*k +: 3]};
    endfunction

    function automatic logic [7:0] read_reg(input ledpb_regs_s r, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == OFS_CONFIG) begin
            v[CFG_RUN_BIT] = r.run;
            v[CFG_FAST_PWM_BIT] = r.fast_pwm;
            v[CFG_EIGHTH_BIT] = r.eighth;
        end else if (a == OFS_GLOBAL) begin
            v = r.global_level;
        end else if (a == OFS_OPEN_CTRL) begin
            v[OPEN_DETECT_BIT] = r.open_detect_enable;
            v[OPEN_REPORT_BIT] = r.open_report_to_pin;
        end else if (a == OFS_BLINK_PERIOD) begin
            v = r.period_pend;
        end else if (a == OFS_BLINK_DUTY) begin
            v = r.duty_pend;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (a == OFS_SCALE + 8'(i)) begin
                v = r.scale_pend[i];
            end
            if (a == OFS_PWM + 8'(i)) begin
                v = r.pwm_pend[i];
            end
        end
        for (int k = 0; k < 3; k++) begin
            if (a == OFS_OPEN_STAT + 8'(k)) begin
                v = pack_six(r.open_status, k);
            end
            if (a == OFS_BLINK_EN + 8'(k)) begin
                v = pack_six(r.blink_en_pend, k);
            end
        end
        return v;
    endfunction

    function automatic ledpb_regs_s write_reg(input ledpb_regs_s r, input logic [7:0] a,
                                              input logic [7:0] v);
        ledpb_regs_s n;
        n = r;
        if (a == OFS_CONFIG) begin
            n.run = v[CFG_RUN_BIT];
            n.fast_pwm = v[CFG_FAST_PWM_BIT]; // RULE_13
            n.eighth = v[CFG_EIGHTH_BIT]; // RULE_10
        end else if (a == OFS_GLOBAL) begin
            n.global_level = v;
        end else if (a == OFS_OPEN_CTRL) begin
            n.open_detect_enable = v[OPEN_DETECT_BIT];
            n.open_report_to_pin = v[OPEN_REPORT_BIT];
        end else if (a == OFS_BLINK_PERIOD) begin
            n.period_pend = v; // RULE_03
        end else if (a == OFS_BLINK_DUTY) begin
            n.duty_pend = v; // RULE_05
        end else if (a == OFS_SCALE_COMMIT && v == COMMIT_KEY) begin
            n.scale_act = r.scale_pend; // RULE_06
        end else if (a == OFS_PWM_BLINK_COMMIT && v == COMMIT_KEY) begin
            n.pwm_act = r.pwm_pend; // RULE_07
            n.period_act = r.period_pend; // RULE_03
            n.duty_act = r.duty_pend; // RULE_05
            n.blink_en_act = r.blink_en_pend; // RULE_19
        end else if (a == OFS_SOFT_RESET && v == SOFT_RESET_KEY) begin
            n = REGS_RESET; // RULE_08
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (a == OFS_SCALE + 8'(i)) begin
                n.scale_pend[i] = v; // RULE_12
            end
            if (a == OFS_PWM + 8'(i)) begin
                n.pwm_pend[i] = v; // RULE_11
            end
        end
        for (int k = 0; k < 3; k++) begin
            if (a == OFS_BLINK_EN + 8'(k)) begin
                n.blink_en_pend[6*k +: 3] = v[2:0]; // RULE_19
                n.blink_en_pend[6*k+3 +: 3] = v[6:4];
            end
        end
        return n;
    endfunction

    always_comb begin
        d = q;
        rd_byte = 8'h00;
        rd_clear = '0;
        wr_stb = 1'b0;

        // Three-stage sampling; a level counts once stages two and three agree
        d.scl_s = {q.scl_s[1:0], I_SCL};
        d.sda_s = {q.sda_s[1:0], I_SDA_IN};
        d.scl_f = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
        d.sda_f = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
        d.sense_s1 = I_OPEN_SENSE;
        d.sense_s2 = q.sense_s1;
        d.sense_s3 = q.sense_s2;
        for (int i = 0; i < NUM_CH; i++) begin
            d.open_f[i] = (q.sense_s2[i] == q.sense_s3[i]) ? q.sense_s3[i] : q.open_f[i];
        end

        scl_rise = d.scl_f && !q.scl_f;
        scl_fall = !d.scl_f && q.scl_f;
        bus_start = q.scl_f && d.scl_f && q.sda_f && !d.sda_f;
        bus_stop = q.scl_f && d.scl_f && !q.sda_f && d.sda_f;

        // Host bus slave with auto-incrementing register pointer
        if (bus_stop) begin
            d.bus = S_IDLE;
            d.sda_oe = 1'b0;
        end else if (bus_start) begin
            d.bus = S_ADDR;
            d.cnt = 4'h0;
            d.full = 1'b0;
            d.sda_oe = 1'b0;
        end else begin
            case (q.bus)
                S_ADDR, S_REG, S_WDATA: begin
                    if (scl_rise && !q.full) begin
                        d.shreg = {q.shreg[6:0], q.sda_f};
                        d.cnt = q.cnt + 4'h1;
                        d.full = (q.cnt == 4'h7);
                    end else if (scl_fall && q.full) begin
                        d.full = 1'b0;
                        d.sda_oe = 1'b1;
                        d.bus = S_ACK;
                        if (q.bus == S_ADDR) begin
                            d.kind = K_ADDR;
                            d.rw = q.shreg[0];
                            if (q.shreg[7:1] != P_BUS_ADDR) begin
                                d.sda_oe = 1'b0;
                                d.bus = S_IDLE;
                            end
                        end else if (q.bus == S_REG) begin
                            d.kind = K_REG;
                            d.ptr = q.shreg;
                        end else begin
                            d.kind = K_DATA;
                            wr_stb = 1'b1;
                            d.regs = write_reg(q.regs, q.ptr, q.shreg);
                            d.ptr = q.ptr + 8'h01;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        d.cnt = 4'h0;
                        if (q.kind == K_ADDR && q.rw) begin
                            rd_byte = read_reg(q.regs, q.ptr);
                            for (int k = 0; k < 3; k++) begin
                                if (q.ptr == OFS_OPEN_STAT + 8'(k)) begin
                                    rd_clear[6*k +: 6] = '1; // RULE_18
                                end
                            end
                            d.ptr = q.ptr + 8'h01;
                            d.sda_oe = !rd_byte[7];
                            d.shreg = {rd_byte[6:0], 1'b0};
                            d.cnt = 4'h1;
                            d.bus = S_RDATA;
                        end else if (q.kind == K_ADDR) begin
                            d.bus = S_REG;
                        end else begin
                            d.bus = S_WDATA;
                        end
                    end
                end
                S_RDATA: begin
                    if (scl_fall) begin
                        if (q.cnt == 4'h8) begin
                            d.sda_oe = 1'b0;
                            d.bus = S_RACK;
                        end else begin
                            d.sda_oe = !q.shreg[7];
                            d.shreg = {q.shreg[6:0], 1'b0};
                            d.cnt = q.cnt + 4'h1;
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        // Master NACK ends the read burst
                        d.bus = q.sda_f ? S_IDLE : S_ACK;
                        d.kind = K_ADDR;
                    end
                end
                default: begin
                    d.sda_oe = 1'b0;
                end
            endcase
        end

        // Open status: a new detection wins over a read clear
        d.regs.open_status = (d.regs.open_status & ~rd_clear)
                           | (q.regs.open_detect_enable ? q.open_f : '0); // RULE_15

        // Shared PWM time base, one counter for every channel
        pwm_limit = q.regs.fast_pwm ? 10'(PWM_FAST_CYC) : 10'(PWM_SLOW_CYC); // RULE_13
        if (q.pwm_pre >= pwm_limit - 10'h001) begin
            d.pwm_pre = 10'h000;
            d.pwm_cnt = q.pwm_cnt + 8'h01; // RULE_14
        end else begin
            d.pwm_pre = q.pwm_pre + 10'h001;
        end

        // Blink phase advances every code+1 base ticks, 256 phases per period
        if (q.blink_tick >= 14'(P_BLINK_TICK - 1)) begin
            d.blink_tick = 14'h0000;
            if (q.blink_sub >= q.regs.period_act) begin
                d.blink_sub = 8'h00;
                d.blink_phase = q.blink_phase + 8'h01; // RULE_01 RULE_02
            end else begin
                d.blink_sub = q.blink_sub + 8'h01;
            end
        end else begin
            d.blink_tick = q.blink_tick + 14'h0001;
        end
        // A shorter committed period must not leave the divider past its new end
        if (d.blink_sub > d.regs.period_act) begin
            d.blink_sub = 8'h00;
        end
        blink_on = q.blink_phase < q.regs.duty_act; // RULE_04

        for (int i = 0; i < NUM_CH; i++) begin
            d.led[i] = q.regs.run // RULE_09
                     && (q.regs.pwm_act[i] > q.pwm_cnt) // RULE_11
                     && (!q.regs.blink_en_act[i] || blink_on); // RULE_20
        end
        d.int_n = !(q.regs.open_report_to_pin && (|q.regs.open_status)); // RULE_16
        d.sda_lo = 1'b0;
    end

    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            q <= '0; // RULE_09
            q.int_n <= 1'b1;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
            // Stages start at the idle-high level so no false edge follows reset
            q.scl_s <= 3'h7;
            q.sda_s <= 3'h7;
        end else begin
            q <= d;
        end
    end

    assign O_SDA_OUT = q.sda_lo;
    assign O_SDA_OE = q.sda_oe;
    assign O_LED_OUTPUT_CHANNEL = q.led;
    assign O_CHANNEL_CURRENT_SCALE = q.regs.scale_act;
    assign O_GLOBAL_CURRENT_LEVEL = q.regs.global_level;
    assign O_EIGHTH_CURRENT_SELECT = q.regs.eighth;
    assign O_RUN_NOT_SHUTDOWN = q.regs.run;
    assign O_INTERRUPT_OUT_N = q.int_n;

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);

    a_shutdown_dark: assert property (!q.regs.run |=> O_LED_OUTPUT_CHANNEL == '0) // RULE_09
        else $error("LED driven while shut down");
    a_int_report: assert property (q.regs.open_report_to_pin // RULE_16
        && |q.regs.open_status |=> !O_INTERRUPT_OUT_N)
        else $error("open not reported on interrupt");
    a_int_quiet: assert property (!q.regs.open_report_to_pin |=> O_INTERRUPT_OUT_N) // RULE_16
        else $error("interrupt low with reporting off");
    a_pwm_commit: assert property (wr_stb && q.ptr == OFS_PWM_BLINK_COMMIT // RULE_07
        && q.shreg == COMMIT_KEY |=> q.regs.pwm_act == $past(q.regs.pwm_pend)
        && q.regs.duty_act == $past(q.regs.duty_pend)
        && q.regs.period_act == $past(q.regs.period_pend))
        else $error("general commit did not apply");
    a_scale_commit: assert property (wr_stb && q.ptr == OFS_SCALE_COMMIT // RULE_06
        && q.shreg == COMMIT_KEY |=> O_CHANNEL_CURRENT_SCALE == $past(q.regs.scale_pend))
        else $error("scaling commit did not apply");
    a_soft_reset: assert property (wr_stb && q.ptr == OFS_SOFT_RESET // RULE_08
        && q.shreg == SOFT_RESET_KEY |=> !O_RUN_NOT_SHUTDOWN && q.regs.pwm_pend == '0)
        else $error("soft reset left registers set");
    a_eighth_mode: assert property (q.regs.eighth |=> O_EIGHTH_CURRENT_SELECT // RULE_10
        || $past(wr_stb))
        else $error("eighth current select lost");
    a_blink_gate: assert property (q.regs.blink_en_act[1] && !blink_on // RULE_20
        |=> !O_LED_OUTPUT_CHANNEL[1])
        else $error("blinking channel on outside window");
    a_duty_zero: assert property (q.regs.duty_act == 8'h00 |-> !blink_on) // RULE_04
        else $error("blink window open at zero duty");
    a_pwm_zero: assert property (q.regs.pwm_act[1] == 8'h00 |=> !O_LED_OUTPUT_CHANNEL[1]) // RULE_11
        else $error("channel on at zero duty");
    a_blink_sub: assert property (q.blink_sub <= q.regs.period_act // RULE_02
        || $past(q.regs.period_act) != q.regs.period_act)
        else $error("blink divider overran period code");

    c_led_on: cover property (O_LED_OUTPUT_CHANNEL[1] && q.regs.blink_en_act[1]);
    c_int_low: cover property (!O_INTERRUPT_OUT_N);
    c_commit: cover property (wr_stb && q.ptr == OFS_PWM_BLINK_COMMIT);
    c_read: cover property (q.bus == S_RDATA);

endmodule

// File: verification/ledpb_host.sv
`timescale 1ns/1ns
module ledpb_host #(
    parameter logic [6:0] P_ADDR = 7'h2A
) (
    input wire logic i_clk,
    input wire logic i_sda_line,
    output logic o_scl,
    output logic o_sda_drv
);
    int nack_cnt = 0;

    initial begin
        o_scl = 1'b1;
        o_sda_drv = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Long set-up so a slave still holding its ack has let go before SCL rises
    task automatic start_cond();
        o_sda_drv <= 1'b1;
        hold(8);
        o_scl <= 1'b1;
        hold(8);
        o_sda_drv <= 1'b0;
        hold(8);
        o_scl <= 1'b0;
        hold(4);
    endtask

    task automatic stop_cond();
        o_sda_drv <= 1'b0;
        hold(4);
        o_scl <= 1'b1;
        hold(8);
        o_sda_drv <= 1'b1;
        hold(8);
    endtask

    // Line sampled in mid high phase, well past the slave's launch latency
    task automatic bit_cyc(input logic b, output logic s);
        o_sda_drv <= b;
        hold(8);
        o_scl <= 1'b1;
        hold(5);
        s = i_sda_line;
        hold(5);
        o_scl <= 1'b0;
        hold(2);
    endtask

    task automatic put_byte(input logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(v[i], s);
        end
        bit_cyc(1'b1, s);
        if (s !== 1'b0) begin
            nack_cnt++;
        end
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        start_cond();
        put_byte({P_ADDR, 1'b0});
        put_byte(ptr);
        put_byte(d);
        stop_cond();
    endtask

    // Single byte read, ended by a master nack
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        logic s;
        start_cond();
        put_byte({P_ADDR, 1'b0});
        put_byte(ptr);
        start_cond();
        put_byte({P_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, s);
            d[i] = s;
        end
        bit_cyc(1'b1, s);
        stop_cond();
    endtask
endmodule

// File: verification/led_pwm_blink_control_test.sv
`timescale 1ns/1ns
module led_pwm_blink_control_test;
    import ledpb_pkg::*;
    localparam int TICK = 14;
    localparam int FAST = 1792;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [NUM_CH-1:0] sense = '0;
    logic scl, sda_drv, sda_out, sda_oe, sda_line, eighth, run, int_n;
    logic [NUM_CH-1:0] led;
    logic [NUM_CH-1:0][7:0] scale;
    logic [7:0] glob;
    logic [7:0] rdv;
    int error_cnt = 0;
    int n_checks = 0;

    always #10 mclk = ~mclk;
    // Open-drain line with pull-up
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

    ledpb_top #(.P_BLINK_TICK(TICK)) dut_u (
        .I_MCLK(mclk), .I_RESET(rst), .I_SCL(scl), .I_SDA_IN(sda_line),
        .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_OPEN_SENSE(sense),
        .O_LED_OUTPUT_CHANNEL(led), .O_CHANNEL_CURRENT_SCALE(scale),
        .O_GLOBAL_CURRENT_LEVEL(glob), .O_EIGHTH_CURRENT_SELECT(eighth),
        .O_RUN_NOT_SHUTDOWN(run), .O_INTERRUPT_OUT_N(int_n)
    );

    ledpb_host #(.P_ADDR(BUS_ADDR_DEFAULT)) host_u (
        .i_clk(mclk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_drv(sda_drv)
    );

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        #1;
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // Exact over any window that is a whole number of periods
    task automatic measure(input int ch, input int n, output int on, output int gap);
        int dark;
        on = 0;
        gap = 0;
        dark = 0;
        repeat (n) begin
            @(posedge mclk);
            #1;
            if (led[ch] === 1'b1) begin
                on++;
                dark = 0;
            end else begin
                dark++;
                gap = (dark > gap) ? dark : gap;
            end
        end
    endtask

    task automatic t_reset();
        chk8("run", 8'h00, {7'h00, run});
        chk8("int_n", 8'h01, {7'h00, int_n});
        chk8("leds", 8'h00, led[7:0]);
        host_u.rd(OFS_BLINK_PERIOD, rdv);
        chk8("period", 8'h00, rdv);
        host_u.rd(OFS_BLINK_DUTY, rdv);
        chk8("duty", 8'h00, rdv);
        host_u.rd(OFS_PWM_BLINK_COMMIT, rdv);
        chk8("commit read", 8'h00, rdv);
    endtask

    task automatic t_config();
        host_u.wr(OFS_CONFIG, 8'h21);
        chk8("run", 8'h01, {7'h00, run});
        chk8("eighth", 8'h01, {7'h00, eighth});
        host_u.wr(OFS_GLOBAL, 8'h20);
        chk8("global", 8'h20, glob);
        host_u.wr(OFS_CONFIG, 8'h03);
        chk8("eighth", 8'h00, {7'h00, eighth});
    endtask

    task automatic t_scale();
        host_u.wr(OFS_SCALE, 8'h80);
        host_u.wr(OFS_SCALE + 8'h11, 8'h5A);
        host_u.rd(OFS_SCALE, rdv);
        chk8("scale pend", 8'h80, rdv);
        chk8("scale0", 8'h00, scale[0]);
        host_u.wr(OFS_SCALE_COMMIT, 8'h11);
        chk8("scale17", 8'h00, scale[17]);
        host_u.wr(OFS_SCALE_COMMIT, COMMIT_KEY);
        chk8("scale0", 8'h80, scale[0]);
        chk8("scale17", 8'h5A, scale[17]);
        chk8("scale1", 8'h00, scale[1]);
    endtask

    task automatic t_pwm();
        int on;
        int g;
        int bad;
        host_u.wr(OFS_PWM, 8'h40);
        host_u.wr(OFS_PWM + 8'h01, 8'hFF);
        measure(0, FAST, on, g);
        chk_rng("pwm0 pend", 0, 0, on);
        host_u.wr(OFS_PWM_BLINK_COMMIT, COMMIT_KEY);
        measure(0, FAST, on, g);
        chk_rng("pwm0", 448, 448, on);
        measure(1, FAST, on, g);
        chk_rng("pwm1", 1785, 1785, on);
        measure(2, FAST, on, g);
        chk_rng("pwm2", 0, 0, on);
        bad = 0;
        repeat (FAST) begin
            @(posedge mclk);
            #1;
            bad += (led[0] === 1'b1 && led[1] !== 1'b1) ? 1 : 0;
        end
        chk_rng("sync", 0, 0, bad);
    endtask

    task automatic t_blink();
        int on;
        int g;
        host_u.wr(OFS_BLINK_EN, 8'h02);
        host_u.wr(OFS_BLINK_DUTY, 8'h80);
        host_u.wr(OFS_BLINK_PERIOD, 8'h01);
        measure(1, 4 * FAST, on, g);
        chk_rng("blink pend", 7140, 7140, on);
        host_u.wr(OFS_PWM_BLINK_COMMIT, COMMIT_KEY);
        measure(1, 8 * FAST, on, g);
        chk_rng("blink on", 7140, 7140, on);
        chk_rng("blink off", 3584, 3598, g);
        host_u.wr(OFS_BLINK_DUTY, 8'h40);
        host_u.wr(OFS_BLINK_PERIOD, 8'h00);
        host_u.wr(OFS_PWM_BLINK_COMMIT, COMMIT_KEY);
        measure(1, 8 * FAST, on, g);
        chk_rng("blink on0", 3556, 3584, on);
        chk_rng("blink off0", 2688, 2702, g);
        host_u.wr(OFS_BLINK_DUTY, 8'h00);
        host_u.wr(OFS_PWM_BLINK_COMMIT, COMMIT_KEY);
        measure(1, FAST, on, g);
        chk_rng("blink zero", 0, 0, on);
    endtask

    task automatic t_open();
        @(posedge mclk);
        sense[4] <= 1'b1;
        host_u.rd(OFS_OPEN_STAT, rdv);
        chk8("open idle", 8'h00, rdv);
        host_u.wr(OFS_OPEN_CTRL, 8'h01);
        @(posedge mclk);
        sense[17] <= 1'b1;
        host_u.hold(10);
        chk8("int_n quiet", 8'h01, {7'h00, int_n});
        host_u.wr(OFS_OPEN_CTRL, 8'h03);
        chk8("int_n", 8'h00, {7'h00, int_n});
        @(posedge mclk);
        sense <= '0;
        host_u.rd(OFS_OPEN_STAT, rdv);
        chk8("open 15h", 8'h20, rdv);
        host_u.rd(OFS_OPEN_STAT + 8'h02, rdv);
        chk8("open 17h", 8'h40, rdv);
        host_u.rd(OFS_OPEN_STAT, rdv);
        chk8("open cleared", 8'h00, rdv);
        host_u.rd(OFS_OPEN_STAT + 8'h02, rdv);
        chk8("open cleared", 8'h00, rdv);
        chk8("int_n idle", 8'h01, {7'h00, int_n});
    endtask

    task automatic t_soft();
        int on;
        int g;
        host_u.wr(OFS_SOFT_RESET, 8'h12);
        chk8("run kept", 8'h01, {7'h00, run});
        host_u.wr(OFS_SOFT_RESET, SOFT_RESET_KEY);
        chk8("run", 8'h00, {7'h00, run});
        chk8("global", 8'h00, glob);
        chk8("scale0", 8'h00, scale[0]);
        host_u.rd(OFS_PWM, rdv);
        chk8("pwm pend", 8'h00, rdv);
        host_u.rd(OFS_OPEN_CTRL, rdv);
        chk8("open ctrl", 8'h00, rdv);
        measure(1, FAST, on, g);
        chk_rng("dark", 0, 0, on);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        t_reset();
        t_config();
        t_scale();
        t_pwm();
        t_blink();
        t_open();
        t_soft();
        chk_rng("host nacks", 0, 0, host_u.nack_cnt);
        report_and_stop();
    end

    // Bounds the whole run
    initial begin
        repeat (95000) @(posedge mclk);
        error_cnt++;
        $display("Error watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule
